/* File: logic/cbsc_consts.svh */
// cbsc_consts.svh: constants for the card socket clock and reset ends.
// assumes: included by bare name, before the package and the modules.
`ifndef CBSC_CONSTS_SVH
`define CBSC_CONSTS_SVH

// ==========================================================
// bus widths and park values
`define CBSC_AD_W          32
`define CBSC_AD_PARK       32'h0000_0000
`define CBSC_AD_PULL       32'hFFFF_FFFF

// ==========================================================
// card clock divider limits; each half period lasts limit+1 clk cycles
`define CBSC_DIV_W         8
`define CBSC_DIV_RUN       8'h00
`define CBSC_DIV_SLOW      8'h07

// ==========================================================
// clock-run timing, in clk cycles
`define CBSC_ANN_W         4
`define CBSC_ANN_CYC       4'h8
`define CBSC_ANN_GRACE     4'h3
`define CBSC_HOLD_CYC      4'h6

// ==========================================================
// card reset release, in card clock rising edges
`define CBSC_REL_W         2
`define CBSC_REL_EDGES     2'h2

`endif

/* File: logic/cbsc_pkg.sv */
// cbsc_pkg.sv: shared types of the card socket clock and reset ends.
// assumes: cbsc_consts.svh is compiled alongside.
package cbsc_pkg;

    // ======================================================
    // requested and reported card clock mode
    typedef enum logic [1:0] {
        CBSC_MODE_RUN,
        CBSC_MODE_SLOW,
        CBSC_MODE_STOP
    } cbsc_mode_t;

    // ======================================================
    // controller clock sequencer states
    typedef enum logic [1:0] {
        CBSC_ST_RUN,
        CBSC_ST_ANNOUNCE,
        CBSC_ST_SLOW,
        CBSC_ST_STOP
    } cbsc_hstate_t;

endpackage

/* File: logic/cbsc_if.sv */
// cbsc_if.sv: socket wires between the controller end and the card end.
// assumes: both ends drive outputs with enables; no wire floats here.
`timescale 1ns/100ps
`include "cbsc_consts.svh"

interface cbsc_if;
    logic                    card_clock;
    logic                    card_reset_n;
    logic                    run_host_o;
    logic                    run_host_oe;
    logic                    run_card_o;
    logic                    run_card_oe;
    logic                    card_clock_run_n;
    logic [`CBSC_AD_W-1:0]   ad_host_o;
    logic                    ad_host_oe;
    logic [`CBSC_AD_W-1:0]   ad_card_o;
    logic                    ad_card_oe;
    logic [`CBSC_AD_W-1:0]   shared_addr_data_lines;

    // ======================================================
    // wire resolution: open drain with pull-up, bus with pull-up
    assign card_clock_run_n = (run_host_oe ? run_host_o : 1'b1)
                            & (run_card_oe ? run_card_o : 1'b1);
    assign shared_addr_data_lines = ad_host_oe ? ad_host_o
                                  : ad_card_oe ? ad_card_o
                                  : `CBSC_AD_PULL;

    modport host (
        output card_clock,
        output card_reset_n,
        output run_host_o,
        output run_host_oe,
        output ad_host_o,
        output ad_host_oe,
        input  card_clock_run_n,
        input  shared_addr_data_lines
    );

    modport card (
        input  card_clock,
        input  card_reset_n,
        input  card_clock_run_n,
        input  shared_addr_data_lines,
        output run_card_o,
        output run_card_oe,
        output ad_card_o,
        output ad_card_oe
    );
endinterface

/* File: logic/cbsc_host.sv */
// cbsc_host.sv: controller end; makes card clock and card reset.
// assumes: clk is the host bus clock; the card sits across cbsc_if.
`timescale 1ns/100ps
`include "cbsc_consts.svh"

module cbsc_host
    import cbsc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    cbsc_if.host                       bus,
    input  wire cbsc_mode_t            mode_req,
    input  wire logic                  reset_req,
    input  wire logic [`CBSC_AD_W-1:0] ad_out,
    input  wire logic                  ad_drive,
    output logic      [`CBSC_AD_W-1:0] ad_seen,
    output cbsc_mode_t                 mode_now,
    output logic                       card_reset_active,
    output logic                       card_woke
);

    // ======================================================
    // helpers
    function automatic logic [`CBSC_DIV_W-1:0] div_limit(
        input cbsc_hstate_t st
    );
        logic [`CBSC_DIV_W-1:0] lim;
        lim = `CBSC_DIV_RUN;
        if (st == CBSC_ST_SLOW) begin
            lim = `CBSC_DIV_SLOW;
        end
        return lim;
    endfunction

    function automatic cbsc_hstate_t low_state(input cbsc_mode_t m);
        return (m == CBSC_MODE_SLOW) ? CBSC_ST_SLOW : CBSC_ST_STOP;
    endfunction

    // ======================================================
    // pin synchronisers
    logic [1:0]            run_sync_q;
    logic [1:0]            run_sync_d;
    logic [`CBSC_AD_W-1:0] ad_s1_q;
    logic [`CBSC_AD_W-1:0] ad_s1_d;
    logic [`CBSC_AD_W-1:0] ad_s2_q;
    logic [`CBSC_AD_W-1:0] ad_s2_d;

    always_comb begin
        run_sync_d = {run_sync_q[0], bus.card_clock_run_n};
        ad_s1_d    = bus.shared_addr_data_lines;
        ad_s2_d    = ad_s1_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            run_sync_q <= 2'h3;
            ad_s1_q    <= `CBSC_AD_PULL;
            ad_s2_q    <= `CBSC_AD_PULL;
        end else if (ce) begin
            run_sync_q <= run_sync_d;
            ad_s1_q    <= ad_s1_d;
            ad_s2_q    <= ad_s2_d;
        end
    end

    // ======================================================
    // clock sequencer, divider and reset release
    cbsc_hstate_t           state_q;
    cbsc_hstate_t           state_d;
    logic [`CBSC_DIV_W-1:0] div_q;
    logic [`CBSC_DIV_W-1:0] div_d;
    logic                   card_clock_q;
    logic                   card_clock_d;
    logic [`CBSC_ANN_W-1:0] ann_q;
    logic [`CBSC_ANN_W-1:0] ann_d;
    logic                   run_oe_q;
    logic                   run_oe_d;
    logic                   wake_hold_q;
    logic                   wake_hold_d;
    logic                   woke_q;
    logic                   woke_d;
    logic                   rstn_q;
    logic                   rstn_d;
    logic [`CBSC_REL_W-1:0] rel_q;
    logic [`CBSC_REL_W-1:0] rel_d;
    logic                   tick;
    logic                   hold_low;
    logic                   rise;
    logic                   run_low;

    always_comb begin
        state_d     = state_q;
        ann_d       = ann_q;
        run_oe_d    = run_oe_q;
        wake_hold_d = wake_hold_q;
        woke_d      = 1'b0;
        rstn_d      = rstn_q;
        rel_d       = rel_q;
        card_clock_d      = card_clock_q;
        run_low     = ~run_sync_q[1];

        // divider: one toggle per limit+1 clk cycles
        tick     = (div_q >= div_limit(state_q));
        div_d    = tick ? '0 : `CBSC_DIV_W'(div_q + 1'b1);
        hold_low = (state_q == CBSC_ST_STOP) && !card_clock_q;
        rise     = tick && !card_clock_q && !hold_low;
        if (tick && !hold_low) begin
            card_clock_d = ~card_clock_q;
        end

        unique case (state_q)
            CBSC_ST_RUN: begin
                run_oe_d = 1'b1;
                if (wake_hold_q && mode_req == CBSC_MODE_RUN) begin
                    wake_hold_d = 1'b0;
                end
                // a held reset keeps the clock at full rate
                if (mode_req != CBSC_MODE_RUN && !wake_hold_q
                    && rstn_q && !reset_req) begin
                    state_d  = CBSC_ST_ANNOUNCE;
                    run_oe_d = 1'b0;
                    ann_d    = `CBSC_ANN_CYC;
                end
            end
            CBSC_ST_ANNOUNCE: begin
                run_oe_d = 1'b0;
                ann_d    = `CBSC_ANN_W'(ann_q - 1'b1);
                if (reset_req || mode_req == CBSC_MODE_RUN) begin
                    state_d  = CBSC_ST_RUN;
                    run_oe_d = 1'b1;
                end else if (run_low
                    && ann_q <= `CBSC_ANN_CYC - `CBSC_ANN_GRACE) begin
                    state_d     = CBSC_ST_RUN;
                    run_oe_d    = 1'b1;
                    wake_hold_d = 1'b1;
                    woke_d      = 1'b1;
                end else if (ann_q == `CBSC_ANN_W'(1)) begin
                    state_d = low_state(mode_req);
                end
            end
            CBSC_ST_SLOW, CBSC_ST_STOP: begin
                run_oe_d = 1'b0;
                if (reset_req) begin
                    state_d  = CBSC_ST_RUN;
                    run_oe_d = 1'b1;
                end else if (run_low) begin
                    state_d     = CBSC_ST_RUN;
                    run_oe_d    = 1'b1;
                    wake_hold_d = 1'b1;
                    woke_d      = 1'b1;
                end else if (mode_req == CBSC_MODE_RUN) begin
                    state_d  = CBSC_ST_RUN;
                    run_oe_d = 1'b1;
                end else begin
                    state_d = low_state(mode_req);
                end
            end
        endcase

        // assert at once; release only as the card clock rises
        if (reset_req) begin
            rstn_d = 1'b0;
            rel_d  = '0;
        end else if (!rstn_q && rise) begin
            if (rel_q == `CBSC_REL_EDGES - 1'b1) begin
                rstn_d = 1'b1;
            end else begin
                rel_d = `CBSC_REL_W'(rel_q + 1'b1);
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            state_q     <= CBSC_ST_RUN;
            div_q       <= '0;
            card_clock_q      <= 1'b0;
            ann_q       <= '0;
            run_oe_q    <= 1'b1;
            wake_hold_q <= 1'b0;
            woke_q      <= 1'b0;
            rstn_q      <= 1'b0;
            rel_q       <= '0;
        end else if (ce) begin
            state_q     <= state_d;
            div_q       <= div_d;
            card_clock_q      <= card_clock_d;
            ann_q       <= ann_d;
            run_oe_q    <= run_oe_d;
            wake_hold_q <= wake_hold_d;
            woke_q      <= woke_d;
            rstn_q      <= rstn_d;
            rel_q       <= rel_d;
        end
    end

    // ======================================================
    // address/data lines: park under reset, sample on rise
    logic [`CBSC_AD_W-1:0] ad_o_q;
    logic [`CBSC_AD_W-1:0] ad_o_d;
    logic                  ad_oe_q;
    logic                  ad_oe_d;
    logic [`CBSC_AD_W-1:0] seen_q;
    logic [`CBSC_AD_W-1:0] seen_d;

    always_comb begin
        // parking follows the next reset value, so no float cycle
        ad_oe_d = !rstn_d || ad_drive;
        ad_o_d  = rstn_d ? ad_out : `CBSC_AD_PARK;
        seen_d  = rise ? ad_s2_q : seen_q;
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            ad_o_q  <= `CBSC_AD_PARK;
            ad_oe_q <= 1'b1;
            seen_q  <= '0;
        end else if (ce) begin
            ad_o_q  <= ad_o_d;
            ad_oe_q <= ad_oe_d;
            seen_q  <= seen_d;
        end
    end

    // ======================================================
    // outputs
    assign bus.card_clock   = card_clock_q;
    assign bus.card_reset_n = rstn_q;
    assign bus.run_host_o   = 1'b0;
    assign bus.run_host_oe  = run_oe_q;
    assign bus.ad_host_o    = ad_o_q;
    assign bus.ad_host_oe   = ad_oe_q;

    assign ad_seen           = seen_q;
    assign card_reset_active = !rstn_q;
    assign card_woke         = woke_q;

    always_comb begin
        unique case (state_q)
            CBSC_ST_SLOW: mode_now = CBSC_MODE_SLOW;
            CBSC_ST_STOP: mode_now = CBSC_MODE_STOP;
            default:      mode_now = CBSC_MODE_RUN;
        endcase
    end

endmodule

/* File: logic/cbsc_card.sv */
// cbsc_card.sv: card end; follows card clock, reset and clock-run.
// assumes: card pins come from another domain and are synchronised.
`timescale 1ns/100ps
`include "cbsc_consts.svh"

module cbsc_card
    import cbsc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  srst,
    input  wire logic                  ce,
    cbsc_if.card                       bus,
    input  wire logic                  need_fast,
    input  wire logic [`CBSC_AD_W-1:0] ad_out,
    input  wire logic                  ad_drive,
    output logic      [`CBSC_AD_W-1:0] ad_sample,
    output logic                       in_reset,
    output logic                       clock_rise,
    output logic                       run_asking
);

    // ======================================================
    // pin synchronisers; third clock stage only finds edges
    logic [2:0]            cck_q;
    logic [2:0]            cck_d;
    logic [1:0]            rst_s_q;
    logic [1:0]            rst_s_d;
    logic [1:0]            run_s_q;
    logic [1:0]            run_s_d;
    logic [`CBSC_AD_W-1:0] ad_s1_q;
    logic [`CBSC_AD_W-1:0] ad_s2_q;

    always_comb begin
        cck_d   = {cck_q[1:0], bus.card_clock};
        rst_s_d = {rst_s_q[0], bus.card_reset_n};
        run_s_d = {run_s_q[0], bus.card_clock_run_n};
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cck_q   <= 3'h0;
            rst_s_q <= 2'h0;
            run_s_q <= 2'h3;
            ad_s1_q <= `CBSC_AD_PULL;
            ad_s2_q <= `CBSC_AD_PULL;
        end else if (ce) begin
            cck_q   <= cck_d;
            rst_s_q <= rst_s_d;
            run_s_q <= run_s_d;
            ad_s1_q <= bus.shared_addr_data_lines;
            ad_s2_q <= ad_s1_q;
        end
    end

    // ======================================================
    // card state
    logic                   rise;
    logic                   held;
    logic [`CBSC_ANN_W-1:0] hold_q;
    logic [`CBSC_ANN_W-1:0] hold_d;
    logic                   rise_q;
    logic                   rise_d;
    logic [`CBSC_AD_W-1:0]  smp_q;
    logic [`CBSC_AD_W-1:0]  smp_d;
    logic [`CBSC_AD_W-1:0]  ad_o_q;
    logic [`CBSC_AD_W-1:0]  ad_o_d;
    logic                   ad_oe_q;
    logic                   ad_oe_d;

    always_comb begin
        held   = !rst_s_q[1];
        rise   = cck_q[1] && !cck_q[2];
        hold_d = hold_q;
        rise_d = rise;
        smp_d  = smp_q;
        ad_o_d = ad_o_q;
        ad_oe_d = ad_oe_q;
        if (held) begin
            hold_d  = '0;
            smp_d   = '0;
            ad_o_d  = '0;
            ad_oe_d = 1'b0;
        end else begin
            // start a pull only while the controller has let the line go
            if (hold_q != '0) begin
                hold_d = `CBSC_ANN_W'(hold_q - 1'b1);
            end else if (need_fast && run_s_q[1]) begin
                hold_d = `CBSC_HOLD_CYC;
            end
            if (rise) begin
                smp_d   = ad_s2_q;
                ad_o_d  = ad_out;
                ad_oe_d = ad_drive;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            hold_q  <= '0;
            rise_q  <= 1'b0;
            smp_q   <= '0;
            ad_o_q  <= '0;
            ad_oe_q <= 1'b0;
        end else if (ce) begin
            hold_q  <= hold_d;
            rise_q  <= rise_d;
            smp_q   <= smp_d;
            ad_o_q  <= ad_o_d;
            ad_oe_q <= ad_oe_d;
        end
    end

    // ======================================================
    // outputs; drop drive the cycle reset is seen, not a cycle late
    assign bus.run_card_o  = 1'b0;
    assign bus.run_card_oe = (hold_q != '0) && !held;
    assign bus.ad_card_o   = ad_o_q;
    assign bus.ad_card_oe  = ad_oe_q && !held;
    assign ad_sample       = smp_q;
    assign in_reset        = held;
    assign clock_rise      = rise_q;
    assign run_asking      = (hold_q != '0);

endmodule

/* File: verification/cbsc_checker.sv */
// cbsc_checker.sv: concurrent checks on the socket wires between both ends.
// assumes: instanced beside cbsc_if in the bench; one clk for both ends.
`timescale 1ns/100ps
`include "cbsc_consts.svh"

module cbsc_checker (
    input wire logic                  clk,
    input wire logic                  srst,
    input wire logic                  card_clock,
    input wire logic                  card_reset_n,
    input wire logic                  run_host_oe,
    input wire logic                  run_card_oe,
    input wire logic [`CBSC_AD_W-1:0] ad_host_o,
    input wire logic                  ad_host_oe,
    input wire logic                  ad_card_oe
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // ======================================================================
    // card clock shape
    // the slowest high phase is 8 clk, so a longer one means a stuck clock
    property p_stop_low;
        $rose(card_clock) |-> ##[1:8] !card_clock;
    endproperty
    a_stop_low: assert property (p_stop_low)
        else $error("card clock held high");

    // a divider left in slow count falls back to full rate at once, as any count meets the full-rate limit
    property p_full_rate;
        run_host_oe [*8] |=> card_clock != $past(card_clock);
    endproperty
    a_full_rate: assert property (p_full_rate)
        else $error("card clock not at full rate");

    property p_announce;
        $fell(run_host_oe) |->
            (!run_host_oe && card_clock != $past(card_clock)) [*3];
    endproperty
    a_announce: assert property (p_announce)
        else $error("rate lowered without announce");

    // ======================================================================
    // card reset
    property p_release_edge;
        $rose(card_reset_n) |-> $rose(card_clock);
    endproperty
    a_release_edge: assert property (p_release_edge)
        else $error("reset released off a card clock edge");

    property p_release_whole;
        $rose(card_reset_n) |-> !$past(card_clock) && $past(card_clock, 2);
    endproperty
    a_release_whole: assert property (p_release_whole)
        else $error("reset release not a whole card clock");

    // two sync flops on the card side explain the three-cycle lead-in
    property p_card_float;
        !card_reset_n [*3] |-> !ad_card_oe && !run_card_oe;
    endproperty
    a_card_float: assert property (p_card_float)
        else $error("card drives pins under reset");

    property p_host_park;
        !card_reset_n |-> ad_host_oe && ad_host_o == `CBSC_AD_PARK;
    endproperty
    a_host_park: assert property (p_host_park)
        else $error("controller leaves lines undriven under reset");

    // ======================================================================
    // clock-run request from the card
    property p_card_pull;
        $rose(run_card_oe) |-> run_card_oe [*6] ##1 !run_card_oe;
    endproperty
    a_card_pull: assert property (p_card_pull)
        else $error("card clock-run pull length wrong");
endmodule

/* File: verification/cbsc_test.sv */
// cbsc_test.sv: self-checking bench, controller end facing card end.
// assumes: design files and cbsc_checker.sv are compiled before it.
`timescale 1ns/100ps
`include "cbsc_consts.svh"

module cbsc_test;
    import cbsc_pkg::*;

    localparam realtime CLK_PERIOD = 40.0;

    // ======================================================================
    // stimulus and observed outputs
    logic                  clk;
    logic                  srst;
    cbsc_mode_t            mode_req;
    logic                  reset_req;
    logic [`CBSC_AD_W-1:0] h_ad_out;
    logic                  h_ad_drive;
    logic [`CBSC_AD_W-1:0] ad_seen;
    cbsc_mode_t            mode_now;
    logic                  card_reset_active;
    logic                  card_woke;
    logic                  need_fast;
    logic [`CBSC_AD_W-1:0] c_ad_out;
    logic                  c_ad_drive;
    logic [`CBSC_AD_W-1:0] ad_sample;
    logic                  in_reset;
    logic                  clock_rise;
    logic                  run_asking;
    int                    err_count = 0;
    int                    cmp_count = 0;

    cbsc_if ifc ();

    cbsc_host u_cbsc_host (.clk(clk), .srst(srst), .ce(1'b1), .bus(ifc),
        .mode_req(mode_req), .reset_req(reset_req), .ad_out(h_ad_out),
        .ad_drive(h_ad_drive), .ad_seen(ad_seen), .mode_now(mode_now),
        .card_reset_active(card_reset_active), .card_woke(card_woke));

    cbsc_card u_cbsc_card (.clk(clk), .srst(srst), .ce(1'b1), .bus(ifc),
        .need_fast(need_fast), .ad_out(c_ad_out), .ad_drive(c_ad_drive),
        .ad_sample(ad_sample), .in_reset(in_reset),
        .clock_rise(clock_rise), .run_asking(run_asking));

    cbsc_checker u_cbsc_checker (.clk(clk), .srst(srst),
        .card_clock(ifc.card_clock), .card_reset_n(ifc.card_reset_n),
        .run_host_oe(ifc.run_host_oe), .run_card_oe(ifc.run_card_oe),
        .ad_host_o(ifc.ad_host_o), .ad_host_oe(ifc.ad_host_oe),
        .ad_card_oe(ifc.ad_card_oe));

    // ======================================================================
    // shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h exp %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask

    // rise to rise, in clk cycles; resumes at a falling edge for driving
    task automatic period(output int p);
        realtime t0;
        @(posedge ifc.card_clock);
        t0 = $realtime;
        @(posedge ifc.card_clock);
        p = int'(($realtime - t0) / CLK_PERIOD);
        @(negedge clk);
    endtask

    task automatic finish_test;
        if (err_count == 0 && cmp_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ======================================================================
    // scenarios
    task automatic t_reset;
        int n;
        chk(card_reset_active, 32'h1, "reset after power up");
        for (n = 0; n < 40 && in_reset !== 1'b0; n++) cyc(1);
        chk(card_reset_active, 32'h0, "reset release");
        chk(in_reset, 32'h0, "card out of reset");
        chk(ifc.ad_card_oe, 32'h0, "idle card lines");
    endtask

    // at full rate the card sees exactly one rise every two clk cycles
    task automatic t_run;
        int         p;
        logic [1:0] r;
        period(p);
        chk(p, 32'h2, "full rate period");
        r = {1'b0, clock_rise};
        cyc(1);
        r = r + {1'b0, clock_rise};
        chk(r, 32'h1, "one card rise per period");
    endtask

    // host drive drops before the card drives its word, as host wins the wire resolution
    task automatic t_data;
        h_ad_out = 32'h8000_0001;
        h_ad_drive = 1'b1;
        repeat (4) @(posedge ifc.card_clock);
        cyc(4);
        chk(ifc.shared_addr_data_lines, 32'h8000_0001, "host word");
        chk(ad_sample, 32'h8000_0001, "card sample");
        h_ad_drive = 1'b0;
        c_ad_out = 32'h7FFF_FFFE;
        c_ad_drive = 1'b1;
        repeat (4) @(posedge ifc.card_clock);
        cyc(4);
        chk(ifc.shared_addr_data_lines, 32'h7FFF_FFFE, "card word");
        chk(ad_seen, 32'h7FFF_FFFE, "host sample");
    endtask

    task automatic t_reset_mid;
        int n;
        reset_req = 1'b1;
        cyc(6);
        chk(card_reset_active, 32'h1, "reset taken");
        chk(in_reset, 32'h1, "card sees reset");
        chk(ad_sample, 32'h0, "card state cleared");
        chk(ifc.ad_card_oe, 32'h0, "card lines released");
        chk(ifc.shared_addr_data_lines, 32'h0, "lines parked");
        reset_req = 1'b0;
        c_ad_drive = 1'b0;
        n = 0;
        while (ifc.card_reset_n !== 1'b1 && n < 10) begin
            @(posedge ifc.card_clock);
            #1;
            n++;
        end
        chk(n, 32'h2, "rises before release");
        cyc(1);
        chk(card_reset_active, 32'h0, "reset released");
    endtask

    task automatic t_slow;
        int p;
        mode_req = CBSC_MODE_SLOW;
        cyc(3);
        chk(ifc.run_host_oe, 32'h0, "clock-run released");
        chk(32'(mode_now), 32'(CBSC_MODE_RUN), "still full rate");
        period(p);
        chk(p, 32'h2, "rate kept in announce");
        cyc(8);
        chk(32'(mode_now), 32'(CBSC_MODE_SLOW), "slow mode");
        period(p);
        period(p);
        chk(p, 32'h10, "slow period");
    endtask

    task automatic t_stop;
        int i;
        mode_req = CBSC_MODE_STOP;
        cyc(20);
        for (i = 0; i < 20; i++) begin
            chk(ifc.card_clock, 32'h0, "stopped clock low");
            chk(clock_rise, 32'h0, "no card rise when stopped");
            cyc(1);
        end
        chk(32'(mode_now), 32'(CBSC_MODE_STOP), "stop mode");
    endtask

    task automatic t_wake;
        int  n;
        int  p;
        logic asked;
        asked = 1'b0;
        need_fast = 1'b1;
        for (n = 0; n < 40 && card_woke !== 1'b1; n++) begin
            asked = asked | (run_asking === 1'b1);
            cyc(1);
        end
        chk(asked, 32'h1, "card asked");
        chk(card_woke, 32'h1, "host woke");
        need_fast = 1'b0;
        mode_req = CBSC_MODE_RUN;
        cyc(2);
        chk(32'(mode_now), 32'(CBSC_MODE_RUN), "back to run");
        cyc(10);
        period(p);
        chk(p, 32'h2, "full rate again");
    endtask

    // a reset request in slow mode must bring full rate back first
    task automatic t_reset_slow;
        int n;
        mode_req = CBSC_MODE_SLOW;
        cyc(14);
        chk(32'(mode_now), 32'(CBSC_MODE_SLOW), "slow before reset");
        reset_req = 1'b1;
        cyc(2);
        chk(32'(mode_now), 32'(CBSC_MODE_RUN), "reset forces run");
        chk(card_reset_active, 32'h1, "reset in slow mode");
        mode_req = CBSC_MODE_RUN;
        reset_req = 1'b0;
        for (n = 0; n < 20 && card_reset_active !== 1'b0; n++) cyc(1);
        chk(card_reset_active, 32'h0, "release after slow");
    endtask

    // ======================================================================
    // clock, main sequence and watchdog
    initial begin
        clk = 1'b0;
        forever #(CLK_PERIOD / 2.0) clk = ~clk;
    end

    initial begin
        srst = 1'b1;
        mode_req = CBSC_MODE_RUN;
        reset_req = 1'b0;
        h_ad_out = 32'h0;
        h_ad_drive = 1'b0;
        need_fast = 1'b0;
        c_ad_out = 32'h0;
        c_ad_drive = 1'b0;
        cyc(3);
        srst = 1'b0;
        cyc(1);
        t_reset();
        t_run();
        t_data();
        t_reset_mid();
        t_slow();
        t_stop();
        t_wake();
        t_reset_slow();
        finish_test();
    end

    // whole run needs well under a thousand clk cycles
    initial begin
        #(CLK_PERIOD * 5000);
        err_count++;
        finish_test();
    end
endmodule
